// ==== rtl/pwmefc_pkg.sv ====
// package: register map, field positions and reset values of the pwm flag/clock block
package pwmefc_pkg;
  localparam logic [7:0] OFS_FLAGS     = 8'h00;
  localparam logic [7:0] OFS_CLKCTRL   = 8'h04;
  localparam logic [7:0] OFS_ENABLE    = 8'h08;
  localparam logic [7:0] OFS_INTEN     = 8'h0c;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam int         FLAG_PERIOD   = 0;
  localparam int         FLAG_DUTY     = 1;
  localparam int         FLAG_PHASE    = 2;
  localparam int         FLAG_OFFSET   = 3;
  localparam int         NUM_FLAGS     = 4;
  localparam int         PS_LSB        = 4;
  localparam int         PS_MSB        = 6;
  localparam int         CS_LSB        = 0;
  localparam int         CS_MSB        = 1;
  localparam logic [3:0] FLAGS_RESET   = 4'h0;
  localparam logic [2:0] PS_RESET      = 3'h0;
  localparam logic [1:0] CS_RESET      = 2'h0;
  localparam logic [1:0] CS_SYSCLK     = 2'h0;
  localparam logic [1:0] CS_FASTOSC    = 2'h1;
  localparam logic [1:0] CS_SLOWOSC    = 2'h2;
  localparam logic [1:0] CS_RESERVED   = 2'h3;
  localparam int         PRESCALE_BITS = 7;
endpackage

// ==== rtl/pwmefc_prescaler.sv ====
// prescaler: divides the selected source ticks by 2^code
`timescale 1ns/1ps
module pwmefc_prescaler #(
  parameter int WIDTH = pwmefc_pkg::PRESCALE_BITS
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             enable,
  input  wire logic             srcTick,
  input  wire logic [2:0]       divideSelect,
  output logic                  divTick
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_divTick;
  logic [WIDTH-1:0] wrapMask;

  always_comb begin
    wrapMask     = WIDTH'((8'h01 << divideSelect) - 8'h01);
    next_count   = count;
    next_divTick = 1'b0;
    if (!enable) begin
      next_count = '0; // see R10
    end else if (srcTick) begin
      if ((count & wrapMask) == wrapMask) begin // see R4
        next_count   = '0;
        next_divTick = 1'b1;
      end else begin
        next_count = count + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count   <= '0;
      divTick <= 1'b0;
    end else begin
      count   <= next_count;
      divTick <= next_divTick;
    end
  end
endmodule // pwmefc_prescaler

// ==== rtl/pwmefc_top.sv ====
// pwm match-event flags and module clock select/prescale, ahb-lite slave
// Behaviour
// R1: four match flags, bits 3..0, upper zero
// R2: software reads/writes flags; hardware only sets
// R3: disabled module holds all flags cleared
// R4: prescale code divides source by 2^code
// R5: source select: system, fast, slow, reserved
// R6: chosen internal oscillator kept running in sleep
// R7: flags set on match rising edge only
// R8: module runs in sleep on internal oscillators
// R9: four interrupt requests, flag and enable
// R10: prescaler held at zero while disabled
`timescale 1ns/1ps
module pwmefc_top (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        offsetMatch,
  input  wire logic        phaseMatch,
  input  wire logic        dutyMatch,
  input  wire logic        periodMatch,
  input  wire logic        sleepActive,
  input  wire logic        fastOscTick,
  input  wire logic        slowOscTick,
  output logic             moduleEnable,
  output logic             fastOscKeepOn,
  output logic             slowOscKeepOn,
  output logic             moduleTick,
  output logic [3:0]       matchIrq
);
  logic [3:0]  match_event_flags;
  logic [2:0]  prescale_divide_select;
  logic [1:0]  clockSource;
  logic [3:0]  irqEnable;
  logic [3:0]  matchPrev;
  logic        wrPending;
  logic [7:0]  wrAddr;
  logic [3:0]  next_flags;
  logic [2:0]  next_ps;
  logic [1:0]  next_cs;
  logic        next_enable;
  logic [3:0]  next_irqEnable;
  logic        next_wrPending;
  logic [7:0]  next_wrAddr;
  logic [31:0] next_hrdata;
  logic [3:0]  matchNow;
  logic [3:0]  matchRise;
  logic        srcTick;
  logic        addrPhase;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrPhase = hsel && hready && htrans[1];
  assign matchNow  = {offsetMatch, phaseMatch, dutyMatch, periodMatch};
  assign matchRise = matchNow & ~matchPrev; // see R7

  // system clock stops in sleep, internal oscillators do not
  always_comb begin
    unique case (clockSource) // see R5
      pwmefc_pkg::CS_SYSCLK:  srcTick = !sleepActive; // see R8
      pwmefc_pkg::CS_FASTOSC: srcTick = fastOscTick;
      pwmefc_pkg::CS_SLOWOSC: srcTick = slowOscTick;
      default:                srcTick = 1'b0;
    endcase
  end
  assign fastOscKeepOn = moduleEnable && (clockSource == pwmefc_pkg::CS_FASTOSC); // see R6
  assign slowOscKeepOn = moduleEnable && (clockSource == pwmefc_pkg::CS_SLOWOSC); // see R6

  pwmefc_prescaler #(
    .WIDTH(pwmefc_pkg::PRESCALE_BITS)
  ) u_pwmefc_prescaler (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .enable       (moduleEnable),
    .srcTick      (srcTick),
    .divideSelect (prescale_divide_select),
    .divTick      (moduleTick)
  );

  always_comb begin
    next_wrPending = addrPhase && hwrite;
    next_wrAddr    = addrPhase ? haddr[7:0] : wrAddr;
    next_flags     = match_event_flags;
    next_ps        = prescale_divide_select;
    next_cs        = clockSource;
    next_enable    = moduleEnable;
    next_irqEnable = irqEnable;
    next_hrdata    = hrdata;
    if (wrPending) begin
      unique case (wrAddr)
        pwmefc_pkg::OFS_FLAGS:   next_flags = hwdata[3:0]; // see R2
        pwmefc_pkg::OFS_CLKCTRL: begin
          next_ps = hwdata[pwmefc_pkg::PS_MSB:pwmefc_pkg::PS_LSB]; // see R4
          next_cs = hwdata[pwmefc_pkg::CS_MSB:pwmefc_pkg::CS_LSB]; // see R5
        end
        pwmefc_pkg::OFS_ENABLE:  next_enable = hwdata[0];
        pwmefc_pkg::OFS_INTEN:   next_irqEnable = hwdata[3:0];
        default:                 next_enable = moduleEnable;
      endcase
    end
    // a match edge in the cycle of a software clear must not be lost
    next_flags = next_flags | matchRise; // see R2, hardware set wins over a write
    if (!next_enable) begin
      next_flags = pwmefc_pkg::FLAGS_RESET; // see R3
    end
    if (addrPhase && !hwrite) begin
      unique case (haddr[7:0])
        pwmefc_pkg::OFS_FLAGS:   next_hrdata = {28'h0, match_event_flags}; // see R1
        pwmefc_pkg::OFS_CLKCTRL: next_hrdata = {25'h0, prescale_divide_select, 2'h0,
                                                clockSource};
        pwmefc_pkg::OFS_ENABLE:  next_hrdata = {31'h0, moduleEnable};
        pwmefc_pkg::OFS_INTEN:   next_hrdata = {28'h0, irqEnable};
        pwmefc_pkg::OFS_STATUS:  next_hrdata = {28'h0, matchIrq};
        default:                 next_hrdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      match_event_flags      <= pwmefc_pkg::FLAGS_RESET;
      prescale_divide_select <= pwmefc_pkg::PS_RESET;
      clockSource            <= pwmefc_pkg::CS_RESET;
      moduleEnable           <= 1'b0;
      irqEnable              <= 4'h0;
      matchPrev              <= 4'h0;
      wrPending              <= 1'b0;
      wrAddr                 <= 8'h00;
      hrdata                 <= 32'h0;
    end else begin
      match_event_flags      <= next_flags;
      prescale_divide_select <= next_ps;
      clockSource            <= next_cs;
      moduleEnable           <= next_enable;
      irqEnable              <= next_irqEnable;
      matchPrev              <= matchNow;
      wrPending              <= next_wrPending;
      wrAddr                 <= next_wrAddr;
      hrdata                 <= next_hrdata;
    end
  end

  assign matchIrq = match_event_flags & irqEnable; // see R9

  // match inputs serve only as antecedents; the checks look at registered state
  a_flag_on_rise: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R7
    (moduleEnable && $rose(offsetMatch)) |=> match_event_flags[pwmefc_pkg::FLAG_OFFSET])
    else $error("offset flag not set on rising match");
  a_phase_rise: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R7
    (moduleEnable && $rose(phaseMatch)) |=> match_event_flags[pwmefc_pkg::FLAG_PHASE])
    else $error("phase flag not set on rising match");
  a_flags_cleared_off: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R3
    !moduleEnable |-> match_event_flags == pwmefc_pkg::FLAGS_RESET)
    else $error("flags not cleared while disabled");
  a_flag_read_upper: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R1
    (addrPhase && !hwrite && haddr[7:0] == pwmefc_pkg::OFS_FLAGS) |=> hrdata[31:4] == 28'h0)
    else $error("flag read upper bits nonzero");
  sequence sWriteFlags;
    addrPhase && hwrite && haddr[7:0] == pwmefc_pkg::OFS_FLAGS && moduleEnable
      ##1 !$rose(matchNow[0]);
  endsequence
  a_flag_sw_write: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R2
    sWriteFlags |=> (match_event_flags[0] == $past(hwdata[0]) || !moduleEnable))
    else $error("software flag write not stored");
  sequence sWriteWord;
    addrPhase && hwrite && haddr[7:0] == pwmefc_pkg::OFS_FLAGS && moduleEnable
      ##1 moduleEnable && !$rose(matchNow[0]) && !$rose(matchNow[1])
        && !$rose(matchNow[2]) && !$rose(matchNow[3]);
  endsequence
  a_flag_sw_word: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R2
    sWriteWord |=> match_event_flags == $past(hwdata[3:0]))
    else $error("software flag word not stored");
  sequence sWriteOff;
    addrPhase && hwrite && haddr[7:0] == pwmefc_pkg::OFS_FLAGS && !moduleEnable
      ##1 !moduleEnable;
  endsequence
  a_flag_write_off: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R3
    sWriteOff |=> match_event_flags == pwmefc_pkg::FLAGS_RESET)
    else $error("flag write stored while disabled");
  a_flag_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R2
    (match_event_flags[1] && moduleEnable && !wrPending) ##1 moduleEnable
      |-> match_event_flags[1])
    else $error("flag dropped without software clear");
  a_irq_request: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R9
    matchIrq[2] == (match_event_flags[2] && irqEnable[2]))
    else $error("phase irq not flag and enable");
  a_irq_follow: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R9
    (moduleEnable && $rose(periodMatch) && irqEnable[pwmefc_pkg::FLAG_PERIOD])
      |=> matchIrq[pwmefc_pkg::FLAG_PERIOD])
    else $error("period irq not raised on match");
  a_keep_slow_osc: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R6
    (moduleEnable && clockSource == pwmefc_pkg::CS_SLOWOSC)
      |-> slowOscKeepOn && !fastOscKeepOn)
    else $error("slow oscillator not kept on");
  a_keep_fast_osc: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R6
    (moduleEnable && clockSource == pwmefc_pkg::CS_FASTOSC)
      |-> fastOscKeepOn && !slowOscKeepOn)
    else $error("fast oscillator not kept on");
  a_keep_none: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R6
    clockSource == pwmefc_pkg::CS_SYSCLK |-> !fastOscKeepOn && !slowOscKeepOn)
    else $error("oscillator kept on for system clock");
  a_sleep_runs: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R8
    (moduleEnable && clockSource == pwmefc_pkg::CS_FASTOSC && prescale_divide_select == 3'h0
      && fastOscTick && $past(moduleEnable)) |=> moduleTick)
    else $error("fast oscillator tick lost");
  a_sysclk_sleep: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R8
    (clockSource == pwmefc_pkg::CS_SYSCLK && sleepActive) [*2] |=> !moduleTick)
    else $error("module ticks in sleep on system clock");
  a_reserved_idle: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R5
    clockSource == pwmefc_pkg::CS_RESERVED |=> !moduleTick)
    else $error("module ticks on reserved source");
  a_divide_two: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R4
    (moduleTick && moduleEnable && prescale_divide_select == 3'h1) |=> !moduleTick)
    else $error("divide by two ticks back to back");
  a_prescale_off: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R10
    !moduleEnable ##1 !moduleEnable |-> !moduleTick)
    else $error("prescaler ticks while disabled");
endmodule // pwmefc_top

// ==== tb/test_pwm_event_flags_clock_select.sv ====
// self-checking bench for the pwm match-flag and clock-select block
`timescale 1ns/1ps
module test_pwm_event_flags_clock_select;
  localparam logic [7:0] FL = pwmefc_pkg::OFS_FLAGS;
  localparam logic [7:0] CK = pwmefc_pkg::OFS_CLKCTRL;
  localparam logic [7:0] EN = pwmefc_pkg::OFS_ENABLE;
  localparam logic [7:0] IE = pwmefc_pkg::OFS_INTEN;
  localparam logic [7:0] ST = pwmefc_pkg::OFS_STATUS;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, moduleEnable, fastOscKeepOn, slowOscKeepOn, moduleTick;
  logic [3:0]  match = 4'h0;
  logic [3:0]  matchIrq;
  logic        sleepActive = 1'b0;
  logic        fastOscTick = 1'b0;
  logic        slowOscTick = 1'b0;
  logic [3:0]  oscCnt = 4'h0;
  int          badCount = 0;
  int          checkCount = 0;
  int          ticks;
  always #12.5 clk_sys = ~clk_sys;
  // fast source ticks every second cycle, slow one every sixteenth
  always @(posedge clk_sys) begin
    oscCnt <= oscCnt + 4'h1;
    fastOscTick <= oscCnt[0];
    slowOscTick <= (oscCnt == 4'h7);
  end
  pwmefc_top u_pwmefc_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .offsetMatch(match[3]),
    .phaseMatch(match[2]), .dutyMatch(match[1]), .periodMatch(match[0]),
    .sleepActive(sleepActive), .fastOscTick(fastOscTick), .slowOscTick(slowOscTick),
    .moduleEnable(moduleEnable), .fastOscKeepOn(fastOscKeepOn),
    .slowOscKeepOn(slowOscKeepOn), .moduleTick(moduleTick), .matchIrq(matchIrq));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // single word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    // the write lands at the data-phase edge; let it settle before anyone looks
    @(posedge clk_sys);
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(name, exp, q);
  endtask
  task automatic hit(input logic [3:0] m);
    match <= m;
    repeat (3) @(posedge clk_sys);
    match <= 4'h0;
    @(posedge clk_sys);
  endtask
  // phase of the divider is usually free, so by default one tick either way is accepted
  task automatic near(input string name, input int cyc, input int e, input int tol = 1);
    ticks = 0;
    repeat (cyc) begin
      @(posedge clk_sys);
      if (moduleTick === 1'b1) ticks++;
    end
    chk(name, 32'h1, {31'h0, ticks >= e - tol && ticks <= e + tol});
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #500000;
    badCount++;
    stopTest();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd("flags", FL, 32'h0);
    rd("clkctrl", CK, 32'h0);
    rd("unmapped", 8'h40, 32'h0);
    hit(4'hf);
    rd("flags off", FL, 32'h0);
    $display("test reset done");
    wr(EN, 32'h1);
    chk("enable", 32'h1, {31'h0, moduleEnable});
    for (int i = 0; i < 4; i++) begin
      hit(4'h1 << i);
      rd("flag", FL, 32'h1 << i);
      wr(FL, 32'h0);
    end
    match <= 4'h2;
    repeat (2) @(posedge clk_sys);
    wr(FL, 32'h0);
    rd("level", FL, 32'h0);
    match <= 4'h0;
    wr(FL, 32'hff);
    rd("sw set", FL, 32'hf);
    wr(IE, 32'h5);
    chk("irq", 32'h5, {28'h0, matchIrq});
    rd("status", ST, 32'h5);
    wr(FL, 32'h0);
    hit(4'h1);
    chk("irq period", 32'h1, {28'h0, matchIrq});
    wr(EN, 32'h0);
    rd("cleared", FL, 32'h0);
    wr(FL, 32'hf);
    rd("held", FL, 32'h0);
    $display("test flags done");
    wr(EN, 32'h1);
    for (int n = 0; n < 8; n++) begin
      wr(CK, n << 4);
      near("divide", 512, 512 >> n);
    end
    wr(EN, 32'h0);
    wr(EN, 32'h1);
    // counter restarts from zero, so the first divide-by-128 tick is seen 129 edges on
    near("restart", 110, 0, 0);
    near("restart tick", 20, 1, 0);
    wr(CK, 32'h1);
    chk("fast on", 32'h1, {31'h0, fastOscKeepOn});
    sleepActive <= 1'b1;
    near("fast sleep", 64, 32);
    wr(CK, 32'h2);
    chk("slow on", 32'h1, {31'h0, slowOscKeepOn});
    near("slow sleep", 64, 4);
    wr(CK, 32'h0);
    chk("no keep", 32'h0, {31'h0, fastOscKeepOn | slowOscKeepOn});
    near("sys sleep", 64, 0, 0);
    sleepActive <= 1'b0;
    wr(CK, 32'h3);
    near("reserved", 64, 0, 0);
    $display("test clock done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk("enable rst", 32'h0, {31'h0, moduleEnable});
    rd("clkctrl rst", CK, 32'h0);
    rd("flags rst", FL, 32'h0);
    $display("test second reset done");
    stopTest();
  end
endmodule // test_pwm_event_flags_clock_select
